// ### dv/ddl_dual_dac_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ddl_dual_dac_ctrl_tb;
  typedef struct packed {
    logic [2:0]  ad;
    logic [15:0] d;
    logic        strobe;
    logic [15:0] a;
    logic [15:0] b;
  } ddl_row_t;

  localparam ddl_row_t ROWS [5] = '{
    '{ddl_pkg::ADDR_CHAN_A, 16'h1234, 1'b0, 16'h1234, 16'h0000},
    '{ddl_pkg::ADDR_CHAN_B, 16'hffff, 1'b0, 16'h1234, 16'hffff},
    '{ddl_pkg::ADDR_ALL,    16'h0001, 1'b0, 16'h0001, 16'h0001},
    '{ddl_pkg::ADDR_CHAN_B, 16'h8000, 1'b0, 16'h0001, 16'h8000},
    '{ddl_pkg::ADDR_CHAN_A, 16'h7777, 1'b1, 16'h0001, 16'h8000}};

  logic        clk, srst, serial_clk, frame_sel_n, serial_in_line, serial_out_line;
  logic        zero_clear_n, output_load_strobe_n, output_clamp_in_n, code_format_select;
  logic        supply_ok, monitor_reset_out, offset_binary, mon_hi;
  logic        gpio_pin_0_out, gpio_pin_0_oe, gpio_pin_1_out, gpio_pin_1_oe;
  logic [15:0] dac_code_a, dac_code_b;
  int          bad_count = 0;
  int          checks_done = 0;
  // Undriven pins float to the weak pull-up level.
  wire logic   gpio_pin_0_in = gpio_pin_0_oe ? gpio_pin_0_out : 1'b1;
  wire logic   gpio_pin_1_in = gpio_pin_1_oe ? gpio_pin_1_out : 1'b1;

  ddl_dual_dac_ctrl i_ddl_dual_dac_ctrl (.clk, .srst, .serial_clk, .frame_sel_n,
    .serial_in_line, .serial_out_line, .zero_clear_n, .output_load_strobe_n,
    .output_clamp_in_n, .code_format_select, .supply_ok, .gpio_pin_0_in, .gpio_pin_0_out,
    .gpio_pin_0_oe, .gpio_pin_1_in, .gpio_pin_1_out, .gpio_pin_1_oe, .monitor_reset_out,
    .dac_code_a, .dac_code_b, .offset_binary);

  ddl_host_model i_ddl_host_model (.serial_clk, .frame_sel_n, .serial_in_line);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [23:0] mk(input logic rd, input logic [2:0] fn,
                                     input logic [2:0] ad, input logic [15:0] d);
    return {rd, fn, 1'b0, ad, d};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The frame is acted on a few cycles after it closes; 20 cycles covers it.
  task automatic settle;
    repeat (20) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #300000;
    bad_count++;
    print_verdict;
  end

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    int n;
    srst = 1'b1;
    zero_clear_n = 1'b1;
    output_load_strobe_n = 1'b0;
    output_clamp_in_n = 1'b1;
    code_format_select = 1'b1;
    supply_ok = 1'b1;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    settle;
    chk(dac_code_a, ddl_pkg::DAC_RST_VAL);
    chk({14'h0, gpio_pin_1_oe, gpio_pin_0_oe}, 16'h0000);
    chk({15'h0000, offset_binary}, 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
      output_load_strobe_n = ROWS[i].strobe;
      i_ddl_host_model.send(mk(1'b0, ddl_pkg::FUNC_DAC, ROWS[i].ad, ROWS[i].d), 24);
      settle;
      chk(dac_code_a, ROWS[i].a);
      chk(dac_code_b, ROWS[i].b);
    end
    i_ddl_host_model.send(mk(1'b0, ddl_pkg::FUNC_DAC, ddl_pkg::ADDR_CHAN_B, 16'h2222), 24);
    settle;
    chk(dac_code_b, 16'h8000);
    output_load_strobe_n = 1'b0;
    n = 0;
    while (dac_code_a === 16'h0001 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(dac_code_a, 16'h7777);
    chk(dac_code_b, 16'h2222);
    i_ddl_host_model.send(mk(1'b1, ddl_pkg::FUNC_DAC, ddl_pkg::ADDR_CHAN_A, 16'h0000), 24);
    settle;
    chk({15'h0000, serial_out_line}, 16'h0001);
    i_ddl_host_model.stray;
    settle;
    chk({15'h0000, serial_out_line}, 16'h0001);
    i_ddl_host_model.send(mk(1'b0, ddl_pkg::FUNC_DAC, ddl_pkg::ADDR_CHAN_A, 16'h3333), 24);
    settle;
    chk({15'h0000, serial_out_line}, 16'h0000);
    chk(dac_code_a, 16'h3333);
    i_ddl_host_model.send(mk(1'b0, ddl_pkg::FUNC_DAC, ddl_pkg::ADDR_CHAN_B, 16'h5555), 23);
    settle;
    chk(dac_code_b, 16'h2222);
    output_clamp_in_n = 1'b0;
    settle;
    chk(dac_code_a | dac_code_b, 16'h0000);
    output_clamp_in_n = 1'b1;
    settle;
    chk(dac_code_a, 16'h3333);
    chk(dac_code_b, 16'h2222);
    zero_clear_n = 1'b0;
    settle;
    chk(dac_code_a, ddl_pkg::CLEAR_CODE);
    chk(dac_code_b, ddl_pkg::CLEAR_CODE);
    zero_clear_n = 1'b1;
    i_ddl_host_model.send(mk(1'b0, ddl_pkg::FUNC_GPIO, ddl_pkg::ADDR_CHAN_A, 16'h0005), 24);
    settle;
    chk({12'h000, gpio_pin_1_oe, gpio_pin_0_oe, gpio_pin_1_out, gpio_pin_0_out}, 16'h0005);
    code_format_select = 1'b0;
    settle;
    chk({15'h0000, offset_binary}, 16'h0000);
    mon_hi = monitor_reset_out;
    supply_ok = 1'b0;
    settle;
    chk({15'h0000, monitor_reset_out}, {15'h0000, ~mon_hi});
    print_verdict;
  end
endmodule

`default_nettype wire

// ### dv/ddl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ddl_host_model (
  output logic serial_clk,
  output logic frame_sel_n,
  output logic serial_in_line
);
  // The link clock idles high and stands still between frames, except when stray toggles it.
  initial
  begin
    serial_clk     = 1'b1;
    frame_sel_n    = 1'b1;
    serial_in_line = 1'b1;
  end

  // A 125 ns period leaves wide margin below the highest allowed link rate.
  task automatic send(input logic [23:0] word, input int nbits);
    for (int i = 0; i < nbits; i++)
    begin
      frame_sel_n    = 1'b0;
      serial_in_line = word[23 - i];
      #62.5 serial_clk = 1'b0;
      #62.5 serial_clk = 1'b1;
    end
    #62.5 frame_sel_n = 1'b1;
    // A released data line must not keep showing the last bit.
    serial_in_line = ~serial_in_line;
    #150;
  endtask

  task automatic stray;
    repeat (4)
    begin
      #62.5 serial_clk = ~serial_clk;
      serial_in_line = ~serial_in_line;
    end
  endtask
endmodule

`default_nettype wire

// ### hw/ddl_dual_dac_ctrl.sv
// Behaviour
// [RULE1] Low frame select shifts input on falling clock.
// [RULE2] Host keeps serial clock at most 30 MHz.
// [RULE3] Host holds input stable at falling edges.
// [RULE4] Shift register contents drive serial output.
// [RULE5] Clear falling edge zeroes every DAC register.
// [RULE6] Load strobe low: update at frame end.
// [RULE7] Load strobe high: only input register updates.
// [RULE8] Load strobe falling edge updates both together.
// [RULE9] Host never leaves load strobe floating.
// [RULE10] Two GPIO pins, direction and readback serial; readback is latched into rd_word but never shifted out.
// [RULE11] GPIO inputs weakly pulled high.
// [RULE12] Clamp input low zeroes outputs, keeps registers.
// [RULE13] Host holds clamp input high normally.
// [RULE14] Monitor reset output follows supply monitor.
// [RULE15] Write frame is 24 bits, acted on after.
// [RULE16] Clear input pulled up, idle high.
// [RULE17] Format select: high offset binary, low twos.
// [RULE18] Frame select high freezes shift register.
// [RULE19] Separate input and DAC registers per channel.
`timescale 1ns/1ps
`default_nettype none

module ddl_dual_dac_ctrl #(
  parameter int SYNC_STAGES = 3
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        serial_clk,
  input  wire logic        frame_sel_n,
  input  wire logic        serial_in_line,
  output logic             serial_out_line,
  input  wire logic        zero_clear_n,
  input  wire logic        output_load_strobe_n,
  input  wire logic        output_clamp_in_n,
  input  wire logic        code_format_select,
  input  wire logic        supply_ok,
  input  wire logic        gpio_pin_0_in,
  output logic             gpio_pin_0_out,
  output logic             gpio_pin_0_oe,
  input  wire logic        gpio_pin_1_in,
  output logic             gpio_pin_1_out,
  output logic             gpio_pin_1_oe,
  output logic             monitor_reset_out,
  output logic [15:0]      dac_code_a,
  output logic [15:0]      dac_code_b,
  output logic             offset_binary
);

  // The synchroniser below is written out for exactly three stages.
  if (SYNC_STAGES != 3)
  begin : g_bad_sync_stages
    $error("ddl_dual_dac_ctrl: SYNC_STAGES must be 3");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; only stages two and three are compared, and a change is
  // accepted once they agree, so the metastable first stage is never read.
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1;
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] pin;
  logic [NPIN-1:0] pin_d;

  // The pad pull-ups of the GPIO pins are modelled by the bench; the bench always drives the clear pin.
  assign pin_raw = {gpio_pin_1_in, gpio_pin_0_in, supply_ok, output_clamp_in_n,
                    output_load_strobe_n, zero_clear_n, frame_sel_n, serial_clk};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Every pin but the load strobe idles high, so a reset value of ones gives no false edge on the others.
      s1    <= 8'hff;
      s2    <= 8'hff;
      s3    <= 8'hff;
      pin   <= 8'hff;
      pin_d <= 8'hff;
    end
    else
    begin
      s1    <= pin_raw;
      s2    <= s1;
      s3    <= s2;
      pin   <= (s2 == s3) ? s3 : pin;
      pin_d <= pin;
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic frame_on;
  logic frame_end;
  logic clr_fall;
  logic ld_fall;
  logic ld_level_n;

  assign sclk_fall  = pin_d[0] & ~pin[0];
  assign sclk_rise  = ~pin_d[0] & pin[0];
  assign frame_on   = ~pin[1];
  assign frame_end  = ~pin_d[1] & pin[1];
  assign clr_fall   = pin_d[2] & ~pin[2];  // [RULE16]
  assign ld_fall    = pin_d[3] & ~pin[3];
  assign ld_level_n = pin[3];

  // ----------------------------------------------------------------
  // Serial shift register
  // ----------------------------------------------------------------
  logic [ddl_pkg::FRAME_BITS-1:0] shreg;
  logic [4:0]                     bit_cnt;
  logic                           sd1;
  logic                           sd2;
  logic                           sd_sync;

  // Serial data takes three stages, one fewer than the clock edge path, so
  // the bit is settled before the synchronised falling edge samples it.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sd1     <= 1'b0;
      sd2     <= 1'b0;
      sd_sync <= 1'b0;
    end
    else
    begin
      sd1     <= serial_in_line;
      sd2     <= sd1;
      sd_sync <= sd2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shreg   <= '0;
      bit_cnt <= 5'h00;
    end
    else if (frame_end)
      bit_cnt <= 5'h00;
    else if (frame_on && sclk_fall)  // [RULE1] [RULE18]
    begin
      shreg   <= {shreg[ddl_pkg::FRAME_BITS-2:0], sd_sync};
      bit_cnt <= (bit_cnt == 5'h18) ? bit_cnt : bit_cnt + 5'h01;
    end
  end

  // Output changes on the rising serial clock so the next part samples it on the fall.
  always_ff @(posedge clk)
  begin
    if (srst)
      serial_out_line <= 1'b0;
    else if (frame_on && sclk_rise)
      serial_out_line <= shreg[ddl_pkg::FRAME_BITS-1];  // [RULE4]
  end

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  logic [2:0]  f_func;
  logic [2:0]  f_addr;
  logic        f_rd;
  logic [15:0] f_data;
  logic        frame_ok;

  assign f_rd     = shreg[ddl_pkg::CMD_POS + ddl_pkg::RD_POS];
  assign f_func   = shreg[ddl_pkg::CMD_POS + ddl_pkg::FUNC_POS +: 3];
  assign f_addr   = shreg[ddl_pkg::CMD_POS + ddl_pkg::ADDR_POS +: 3];
  assign f_data   = shreg[ddl_pkg::DATA_W-1:0];
  assign frame_ok = frame_end && (bit_cnt == 5'd24) && !f_rd;  // [RULE15]

  function automatic logic hits(input logic [2:0] a, input logic [2:0] ch);
    return (a == ch) || (a == ddl_pkg::ADDR_ALL);
  endfunction

  // ----------------------------------------------------------------
  // Input and DAC registers
  // ----------------------------------------------------------------
  logic [15:0] in_reg [2];
  logic [15:0] dac_reg [2];
  logic        wr_dac;

  assign wr_dac = frame_ok && (f_func == ddl_pkg::FUNC_DAC);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      in_reg[0]  <= ddl_pkg::DAC_RST_VAL;
      in_reg[1]  <= ddl_pkg::DAC_RST_VAL;
      dac_reg[0] <= ddl_pkg::DAC_RST_VAL;
      dac_reg[1] <= ddl_pkg::DAC_RST_VAL;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wr_dac && hits(f_addr, 3'(c)))
          in_reg[c] <= f_data;  // [RULE7] [RULE19]
        if (clr_fall)
          dac_reg[c] <= ddl_pkg::CLEAR_CODE;  // [RULE5]
        else if (ld_fall)
          dac_reg[c] <= in_reg[c];  // [RULE8]
        else if (wr_dac && hits(f_addr, 3'(c)) && !ld_level_n)
          dac_reg[c] <= f_data;  // [RULE6]
      end
    end
  end

  // Clamp gates only the outputs; the stored codes survive it.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dac_code_a <= 16'h0000;
      dac_code_b <= 16'h0000;
    end
    else
    begin
      dac_code_a <= pin[4] ? dac_reg[0] : ddl_pkg::CLEAR_CODE;  // [RULE12]
      dac_code_b <= pin[4] ? dac_reg[1] : ddl_pkg::CLEAR_CODE;  // [RULE12]
    end
  end

  // The format strap is sampled every cycle after reset release, never under reset.
  always_ff @(posedge clk)
  begin
    if (srst)
      offset_binary <= 1'b1;
    else
      offset_binary <= code_format_select;  // [RULE17]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      monitor_reset_out <= 1'b0;
    else
      monitor_reset_out <= pin[5];  // [RULE14]
  end

  // ----------------------------------------------------------------
  // GPIO port
  // ----------------------------------------------------------------
  logic [1:0] gpio_dir;
  logic [1:0] gpio_lvl;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      gpio_dir <= ddl_pkg::GPIO_DIR_RST;
      gpio_lvl <= 2'h0;
    end
    else if (frame_ok && f_func == ddl_pkg::FUNC_GPIO)
    begin
      gpio_dir <= f_data[ddl_pkg::GPIO_DIR_POS +: 2];  // [RULE10]
      gpio_lvl <= f_data[ddl_pkg::GPIO_OUT_POS +: 2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      gpio_pin_0_oe  <= 1'b0;
      gpio_pin_1_oe  <= 1'b0;
      gpio_pin_0_out <= 1'b0;
      gpio_pin_1_out <= 1'b0;
    end
    else
    begin
      gpio_pin_0_oe  <= gpio_dir[0];  // [RULE11]
      gpio_pin_1_oe  <= gpio_dir[1];
      gpio_pin_0_out <= gpio_lvl[0];
      gpio_pin_1_out <= gpio_lvl[1];
    end
  end

  // Pin states for readback; GPIO read frames latch them into rd_word at frame end, which drives no output.
  logic rd_frame;
  assign rd_frame = frame_end && (bit_cnt == 5'd24) && f_rd;

  logic [15:0] rd_word;
  always_ff @(posedge clk)
  begin
    if (srst)
      rd_word <= 16'h0000;
    else if (rd_frame)
      rd_word <= (f_func == ddl_pkg::FUNC_GPIO) ? {12'h000, pin[7:6], gpio_dir}
               : in_reg[f_addr[0]];  // [RULE10]
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence clr_edge_s;
    clr_fall;
  endsequence

  clear_zero_a: assert property (@(posedge clk) disable iff (srst)  // [RULE5]
    clr_edge_s |=> (dac_reg[0] == 16'h0000 && dac_reg[1] == 16'h0000))
    else $error("clear did not zero DAC registers");

  output_load_strobe_n_both_a: assert property (@(posedge clk) disable iff (srst)  // [RULE8]
    (ld_fall && !clr_fall) |=> (dac_reg[0] == $past(in_reg[0]) && dac_reg[1] == $past(in_reg[1])))
    else $error("load strobe did not update both channels");

  frozen_shift_a: assert property (@(posedge clk) disable iff (srst)  // [RULE18]
    (pin[1] && !frame_end) |=> $stable(shreg))
    else $error("shift register changed outside frame");

  deferred_hold_a: assert property (@(posedge clk) disable iff (srst)  // [RULE7]
    (wr_dac && ld_level_n && !clr_fall) |=> $stable(dac_reg[0]) && $stable(dac_reg[1]))
    else $error("DAC updated while load strobe high");

  clamp_out_a: assert property (@(posedge clk) disable iff (srst)  // [RULE12]
    !pin[4] |=> dac_code_a == 16'h0000 && dac_code_b == 16'h0000)
    else $error("outputs not clamped");

  clamp_keep_a: assert property (@(posedge clk) disable iff (srst)  // [RULE12]
    (!pin[4] && !clr_fall && !ld_fall && !wr_dac) |=> $stable(dac_reg[0]))
    else $error("clamp disturbed register");

  bit_count_a: assert property (@(posedge clk) disable iff (srst)  // [RULE15]
    bit_cnt <= 5'd24)
    else $error("bit counter overran");

  gpio_dir_a: assert property (@(posedge clk) disable iff (srst)  // [RULE10]
    (frame_ok && f_func == ddl_pkg::FUNC_GPIO) |=> ##1 gpio_pin_0_oe == $past(f_data[0], 2))
    else $error("GPIO direction not applied");

endmodule

`default_nettype wire

// ### hw/ddl_pkg.sv
package ddl_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int CMD_POS    = 16;
  localparam int CMD_W      = 8;
  localparam int DATA_W     = 16;

  // Command byte: bit 7 read, bits 6:4 function, bits 2:0 target.
  localparam int RD_POS     = 7;
  localparam int FUNC_POS   = 4;
  localparam int ADDR_POS   = 0;

  localparam logic [2:0] FUNC_DAC    = 3'h0;
  localparam logic [2:0] FUNC_GPIO   = 3'h1;
  localparam logic [2:0] FUNC_DAISY  = 3'h2;
  localparam logic [2:0] ADDR_CHAN_A = 3'h0;
  localparam logic [2:0] ADDR_CHAN_B = 3'h1;
  localparam logic [2:0] ADDR_ALL    = 3'h4;

  // GPIO data bits: [1:0] direction (1 = output), [3:2] output levels.
  localparam int GPIO_DIR_POS = 0;
  localparam int GPIO_OUT_POS = 2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] CLEAR_CODE    = 16'h0000;
  localparam logic [15:0] DAC_RST_VAL   = 16'h0000;
  localparam logic [1:0]  GPIO_DIR_RST  = 2'h0;
  localparam int          CLK_MHZ       = 100;
  localparam int          SCLK_MAX_MHZ  = 30;

endpackage
